// ### logic/result_readout.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1 - Result words are 16 bits; top bit is one when the word holds valid data.
// RULE2 - Bits 14..12 carry channel tag, pair A/B/C first/second as 000..101.
// RULE3 - The 12-bit result sits in bits 11..0, MSB at bit 11.
// RULE4 - Byte mode: first read gives low eight bits, second read the upper bits.
// RULE5 - Mode lines are sampled only while read strobe and chip select are both low.
// RULE6 - Reset sets the internal mode selection to 000.
// RULE7 - Codes 000..101 select one channel result directly, in tag order.
// RULE8 - Host sets the address before the read strobe falls and holds it.
// RULE9 - Code 110 cycles reads through A first..C second, then wraps.
// RULE10 - After reset the first cycle-mode read returns pair A first.
// RULE11 - Code 111 reads stored results in conversion order.
// RULE12 - Host does one read at code 111 before the first conversion.
// RULE13 - A result arriving during a read is latched after the strobe rises.
// RULE14 - Reset cancels conversions, clears outputs and returns pairs to sampling.
// RULE15 - Trigger queued at falling clock edge; idle converter starts at next rise.
// RULE16 - Same-cycle triggers: pair A first, pair C after earlier queued pairs.
// RULE17 - In FIFO mode bit 15 is low when empty, high when holding a result.
// RULE18 - New results go to lowest free slots, first then second channel.
// RULE19 - Completed read of slot 0 discards it and shifts the rest down.
// RULE20 - FIFO holds three results per channel of one busy pair.
// RULE21 - Data outputs are driven only while chip select and read strobe are low.
// RULE22 - Result latched 12.5 clocks after start; a conversion takes 16 clocks.
// RULE23 - Further trigger pulses are ignored until that pair's conversion ends; the code re-arms the pair at its result latch, 12.5 clocks after start.
// RULE24 - Same-cycle triggers convert in order pair A, pair B, pair C.
// RULE25 - Cycle pointer and FIFO pop advance at the end of a whole word read.
// RULE26 - Byte half selector returns low after reset and after each full word.
module result_readout
	import readout_pkg::*;
#(
	parameter int HALF_CYCLES = CONV_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          reset_i,
	// Host pins
	input  wire logic                          read_strobe_n_i,
	input  wire logic                          chip_select_n_i,
	input  wire logic                          byte_mode_i,
	input  wire logic [2:0]                    mode_select_i,
	output logic      [WORD_W-1:0]             data_o,
	output logic                               data_oe_o,
	// Sample triggers, active low
	input  wire logic [NUM_PAIRS-1:0]          sample_trigger_n_i,
	// Converter core
	input  wire logic [RESULT_W-1:0]           core_first_i,
	input  wire logic [RESULT_W-1:0]           core_second_i,
	output logic      [1:0]                    core_pair_o,
	output logic                               busy_n_o,
	output logic      [NUM_PAIRS-1:0]          hold_o
);

	// Divider needs at least one clock per conversion-clock half
	if (HALF_CYCLES < 1) begin
		$error("HALF_CYCLES must be at least 1");
	end

	// ==================================================
	// Pin synchronisers
	// ==================================================
	host_pins_t               pins_raw;
	host_pins_t               pins;
	logic [NUM_PAIRS-1:0]     trig_n;

	assign pins_raw = '{read_strobe_n: read_strobe_n_i, chip_select_n: chip_select_n_i,
		byte_mode: byte_mode_i, mode_select: mode_select_i};

	bit_sync #(
		.WIDTH     ($bits(host_pins_t) + NUM_PAIRS),
		.RESET_VAL ({1'b1, 1'b1, 1'b0, 3'h0, {NUM_PAIRS{1'b1}}})
	) u_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.async_i ({pins_raw, sample_trigger_n_i}),
		.sync_o  ({pins, trig_n})
	);

	// ==================================================
	// Conversion clock enables
	// ==================================================
	logic [$clog2(HALF_CYCLES+1)-1:0] div_cnt;
	logic                             conv_clk;
	logic                             rise_en;
	logic                             fall_en;

	assign rise_en = (div_cnt == HALF_CYCLES - 1) && !conv_clk;
	assign fall_en = (div_cnt == HALF_CYCLES - 1) && conv_clk;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			div_cnt  <= '0;
			conv_clk <= 1'b0;
		end else if (div_cnt == HALF_CYCLES - 1) begin
			div_cnt  <= '0;
			conv_clk <= !conv_clk;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// ==================================================
	// Trigger capture and queue
	// ==================================================
	logic [NUM_PAIRS-1:0] trig_prev;
	logic [NUM_PAIRS-1:0] trig_fall;
	logic [NUM_PAIRS-1:0] seen;
	logic [NUM_PAIRS-1:0] armed;
	logic [1:0]           queue [NUM_PAIRS];
	logic [1:0]           q_cnt;
	logic [1:0]           next_queue [NUM_PAIRS];
	logic [1:0]           next_q_cnt;
	logic                 start;
	logic                 latch_evt;
	conv_state_t          state;
	logic [5:0]           half;
	logic [1:0]           cur_pair;

	assign trig_fall = trig_prev & ~trig_n & ~armed; // RULE23

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			trig_prev <= {NUM_PAIRS{1'b1}};
			armed     <= '0;
			seen      <= '0;
		end else begin
			trig_prev <= trig_n;
			// A new trigger in the latch cycle is still masked, so the clear at latch wins
			armed     <= (armed & ~(latch_evt ? (3'h1 << cur_pair) : 3'h0)) | trig_fall; // RULE23
			seen      <= fall_en ? trig_fall : (seen | trig_fall); // RULE15
		end
	end

	// Append pairs caught this clock period in A, B, C order
	always_comb begin
		logic [1:0] n;
		n = q_cnt;
		for (int i = 0; i < NUM_PAIRS; i++)
			next_queue[i] = queue[i];
		if (start) begin
			next_queue[0] = queue[1];
			next_queue[1] = queue[2];
			next_queue[2] = 2'h0;
			n = q_cnt - 1'b1;
		end
		if (fall_en) begin
			for (int p = 0; p < NUM_PAIRS; p++) begin
				if (seen[p] && n < 2'(NUM_PAIRS)) begin
					next_queue[n] = 2'(p); // RULE16 RULE24
					n = n + 1'b1;
				end
			end
		end
		next_q_cnt = n;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			q_cnt <= '0;
			for (int i = 0; i < NUM_PAIRS; i++)
				queue[i] <= 2'h0;
		end else begin
			q_cnt <= next_q_cnt; // RULE15
			for (int i = 0; i < NUM_PAIRS; i++)
				queue[i] <= next_queue[i];
		end
	end

	// ==================================================
	// Conversion sequencer
	// ==================================================
	assign start = rise_en && (q_cnt != 2'h0) &&
		(state == CONV_IDLE || (state == CONV_ACQ && half == 6'(TOTAL_HALF_EDGES - 1))); // RULE15 RULE22
	assign latch_evt = fall_en && state == CONV_RUN && half == 6'(LATCH_HALF_EDGES - 1); // RULE22

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state    <= CONV_IDLE; // RULE14
			half     <= '0;
			cur_pair <= 2'h0;
			busy_n_o <= 1'b1;
		end else if (start) begin
			state    <= CONV_RUN;
			half     <= '0;
			cur_pair <= queue[0];
			busy_n_o <= 1'b0;
		end else if (rise_en || fall_en) begin
			case (state)
				CONV_RUN: begin
					half <= half + 1'b1;
					if (latch_evt) begin
						state    <= CONV_ACQ;
						busy_n_o <= 1'b1;
					end
				end
				CONV_ACQ: begin
					if (half == 6'(TOTAL_HALF_EDGES - 1))
						state <= CONV_IDLE; // RULE22
					else
						half <= half + 1'b1;
				end
				default: half <= '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			core_pair_o <= 2'h0;
			hold_o      <= '0; // RULE14
		end else begin
			if (start)
				core_pair_o <= queue[0];
			hold_o <= (hold_o & ~(latch_evt ? (3'h1 << cur_pair) : 3'h0)) | trig_fall;
		end
	end

	// ==================================================
	// Host read tracking
	// ==================================================
	logic       read_act;
	logic       reading;
	logic       read_end;
	logic       word_done;
	logic [2:0] mode;
	logic       byte_half;
	logic [2:0] cyc_ptr;
	logic [2:0] fifo_cnt;
	logic       pop;

	assign read_act  = !pins.read_strobe_n && !pins.chip_select_n;
	assign read_end  = reading && !read_act;
	assign word_done = read_end && (!pins.byte_mode || byte_half); // RULE25
	assign pop       = word_done && mode == MODE_FIFO && fifo_cnt != 3'h0; // RULE19

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			reading <= 1'b0;
			mode    <= MODE_RESET; // RULE6
		end else begin
			reading <= read_act;
			if (read_act)
				mode <= pins.mode_select; // RULE5 RULE8
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			byte_half <= 1'b0; // RULE26
		else if (word_done)
			byte_half <= 1'b0; // RULE26
		else if (read_end && pins.byte_mode)
			byte_half <= 1'b1; // RULE4
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			cyc_ptr <= 3'h0; // RULE10
		else if (word_done && mode == MODE_CYCLE)
			cyc_ptr <= (cyc_ptr == 3'(NUM_CHANNELS - 1)) ? 3'h0 : cyc_ptr + 1'b1; // RULE9
	end

	// ==================================================
	// Result latch, held off while a read is in progress
	// ==================================================
	logic                pend;
	logic [1:0]          pend_pair;
	logic [RESULT_W-1:0] pend_first;
	logic [RESULT_W-1:0] pend_second;
	logic                commit;
	result_word_t        word_a;
	result_word_t        word_b;

	assign commit = pend && pins.read_strobe_n; // RULE13
	assign word_a = '{valid: 1'b1, tag: {pend_pair, 1'b0}, data: pend_first}; // RULE1 RULE2 RULE3
	assign word_b = '{valid: 1'b1, tag: {pend_pair, 1'b1}, data: pend_second};

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pend        <= 1'b0;
			pend_pair   <= 2'h0;
			pend_first  <= '0;
			pend_second <= '0;
		end else if (latch_evt) begin
			pend        <= 1'b1;
			pend_pair   <= cur_pair;
			pend_first  <= core_first_i;
			pend_second <= core_second_i;
		end else if (commit) begin
			pend <= 1'b0;
		end
	end

	// ==================================================
	// Direct channel registers
	// ==================================================
	result_word_t chan [NUM_CHANNELS];

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			for (int i = 0; i < NUM_CHANNELS; i++)
				chan[i] <= '0; // RULE14
		end else if (commit) begin
			chan[{pend_pair, 1'b0}] <= word_a; // RULE7
			chan[{pend_pair, 1'b1}] <= word_b;
		end
	end

	// ==================================================
	// FIFO registers, slot 0 is the head
	// ==================================================
	result_word_t fifo [FIFO_DEPTH];
	logic [2:0]   base;

	assign base = fifo_cnt - {2'h0, pop};

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			fifo_cnt <= 3'h0;
			for (int i = 0; i < FIFO_DEPTH; i++)
				fifo[i] <= '0; // RULE14
		end else begin
			if (pop) begin
				for (int i = 0; i < FIFO_DEPTH - 1; i++)
					fifo[i] <= fifo[i + 1]; // RULE19
				fifo[FIFO_DEPTH - 1] <= '0;
			end
			// A whole pair is stored only if both slots are free
			if (commit && base <= 3'(FIFO_DEPTH - 2)) begin
				fifo[base]        <= word_a; // RULE18 RULE20 RULE11
				fifo[base + 3'h1] <= word_b;
				fifo_cnt          <= base + 3'h2;
			end else begin
				fifo_cnt <= base;
			end
		end
	end

	// ==================================================
	// Output word
	// ==================================================
	result_word_t sel;
	logic [WORD_W-1:0] next_data;

	always_comb begin
		case (mode)
			MODE_CYCLE: sel = chan[cyc_ptr]; // RULE9
			MODE_FIFO:  sel = fifo[0]; // RULE17 RULE11
			default: begin
				if (mode <= MODE_LAST_DIRECT)
					sel = chan[mode]; // RULE7
				else
					sel = '0;
			end
		endcase
		if (pins.byte_mode)
			next_data = byte_half ? {8'h00, sel[WORD_W-1:LOW_BYTE_TOP_LINE+1]}
				: {8'h00, sel[LOW_BYTE_TOP_LINE:0]}; // RULE4
		else
			next_data = sel;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			data_o    <= '0;
			data_oe_o <= 1'b0;
		end else begin
			data_o    <= next_data;
			data_oe_o <= read_act; // RULE21
		end
	end

endmodule

`default_nettype wire

// ### inc/readout_pkg.sv
package readout_pkg;

	// ==================================================
	// Word layout
	// ==================================================
	localparam int WORD_W        = 16;
	localparam int RESULT_W      = 12;
	localparam int TAG_W         = 3;
	localparam int VALID_FLAG_BIT = 15;
	localparam int CHANNEL_TAG_MSB = 14;
	localparam int CHANNEL_TAG_LSB = 12;
	localparam int RESULT_MSB    = 11;
	localparam int RESULT_LSB    = 0;
	localparam int LOW_BYTE_TOP_LINE = 7;
	localparam int NUM_PAIRS     = 3;
	localparam int NUM_CHANNELS  = 6;
	localparam int FIFO_DEPTH    = 6;

	// ==================================================
	// Address and mode codes
	// ==================================================
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_LAST_DIRECT = 3'h5;
	localparam logic [2:0] MODE_CYCLE = 3'h6;
	localparam logic [2:0] MODE_FIFO  = 3'h7;

	// ==================================================
	// Conversion clock and timing
	// ==================================================
	localparam int MCLK_HZ          = 50_000_000;
	localparam int CONV_CLK_PERIOD_NS = 160;
	localparam int CONV_CLK_CYCLES  = (CONV_CLK_PERIOD_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CONV_HALF_CYCLES = CONV_CLK_CYCLES / 2;
	localparam int LATCH_HALF_EDGES = 25;
	localparam int TOTAL_HALF_EDGES = 32;

	// ==================================================
	// Carriers
	// ==================================================
	typedef struct packed {
		logic                valid;
		logic [TAG_W-1:0]    tag;
		logic [RESULT_W-1:0] data;
	} result_word_t;

	typedef struct packed {
		logic       read_strobe_n;
		logic       chip_select_n;
		logic       byte_mode;
		logic [2:0] mode_select;
	} host_pins_t;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_RUN,
		CONV_ACQ
	} conv_state_t;

endpackage

// ### logic/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	// Two flops; only the second is read downstream
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			stage1 <= RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule

`default_nettype wire

// ### test/result_readout_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Port checks
// ==================================================
module result_readout_asserts
	import readout_pkg::*;
#(
	parameter int HALF_CYCLES = CONV_HALF_CYCLES
) (
	// Clock and reset
	input wire logic                 mclk_i,
	input wire logic                 reset_i,
	// Host pins
	input wire logic                 read_strobe_n_i,
	input wire logic                 chip_select_n_i,
	input wire logic                 byte_mode_i,
	input wire logic [2:0]           mode_select_i,
	input wire logic [WORD_W-1:0]    data_o,
	input wire logic                 data_oe_o,
	// Converter side
	input wire logic [NUM_PAIRS-1:0] sample_trigger_n_i,
	input wire logic [RESULT_W-1:0]  core_first_i,
	input wire logic [RESULT_W-1:0]  core_second_i,
	input wire logic [1:0]           core_pair_o,
	input wire logic                 busy_n_o,
	input wire logic [NUM_PAIRS-1:0] hold_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	logic [15:0] busy_cnt;
	logic [15:0] gap_cnt;
	logic        busy_prev;

	// Length of each busy phase and spacing of conversion starts
	always_ff @(posedge mclk_i) begin
		busy_prev <= busy_n_o;
		busy_cnt <= (reset_i || busy_n_o) ? 16'h0 : busy_cnt + 16'h1;
		if (reset_i) begin
			gap_cnt <= 16'hffff;
		end else if (busy_prev && !busy_n_o) begin
			gap_cnt <= 16'h0;
		end else if (gap_cnt != 16'hffff) begin
			gap_cnt <= gap_cnt + 16'h1;
		end
	end

	reset_clear_a: assert property ($fell(reset_i) |-> data_o == '0 && !data_oe_o
		&& busy_n_o && hold_o == '0) else $error("outputs not cleared by reset");
	bus_release_a: assert property (read_strobe_n_i [*5] |-> !data_oe_o)
		else $error("data driven without a read");
	busy_length_a: assert property ($rose(busy_n_o) |-> busy_cnt >= 24 * HALF_CYCLES
		&& busy_cnt <= 26 * HALF_CYCLES) else $error("busy phase length wrong");
	conv_gap_a: assert property ($fell(busy_n_o) |-> gap_cnt >= 32 * HALF_CYCLES - 2)
		else $error("conversions started too close");
	pair_armed_a: assert property ($fell(busy_n_o) |-> hold_o[core_pair_o])
		else $error("conversion of a pair not in hold");
	hold_release_a: assert property ($rose(busy_n_o) |-> ##[0:1] !hold_o[core_pair_o])
		else $error("hold not released at latch");
	tag_range_a: assert property (data_oe_o && data_o[VALID_FLAG_BIT] |->
		data_o[CHANNEL_TAG_MSB:CHANNEL_TAG_LSB] <= 3'h5) else $error("bad channel tag");
	byte_upper_a: assert property (byte_mode_i && $past(byte_mode_i, 4) && data_oe_o
		|-> data_o[15:8] == 8'h00) else $error("upper lines driven in byte mode");
	data_stable_a: assert property (data_oe_o && $past(data_oe_o, 2) |-> $stable(data_o))
		else $error("output word changed during a read");
endmodule

bind result_readout result_readout_asserts #(.HALF_CYCLES(HALF_CYCLES)) result_readout_asserts_i (
	.mclk_i(mclk_i), .reset_i(reset_i), .read_strobe_n_i(read_strobe_n_i),
	.chip_select_n_i(chip_select_n_i), .byte_mode_i(byte_mode_i),
	.mode_select_i(mode_select_i), .data_o(data_o), .data_oe_o(data_oe_o),
	.sample_trigger_n_i(sample_trigger_n_i), .core_first_i(core_first_i),
	.core_second_i(core_second_i), .core_pair_o(core_pair_o), .busy_n_o(busy_n_o),
	.hold_o(hold_o)
);

`default_nettype wire

// ### test/readout_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Host reading over the parallel port
// ==================================================
module readout_host_model
	import readout_pkg::*;
(
	// Clock
	input wire logic              mclk_i,
	// Bus
	input wire logic [WORD_W-1:0] data_o,
	input wire logic              data_oe_o,
	output var host_pins_t        pins_o
);
	initial pins_o = '{1'b1, 1'b1, 1'b0, 3'h0};

	// Mode set a cycle ahead and held while the strobe is low; hold adds low cycles
	task automatic read_hold(input logic [2:0] mode, input logic bm, input int hold,
		output logic [WORD_W-1:0] w, output logic [WORD_W-1:0] w_late);
		int n;
		@(posedge mclk_i);
		pins_o.mode_select <= mode;
		pins_o.byte_mode <= bm;
		@(posedge mclk_i);
		pins_o.read_strobe_n <= 1'b0;
		pins_o.chip_select_n <= 1'b0;
		n = 0;
		while (data_oe_o !== 1'b1 && n < 10) begin
			@(posedge mclk_i);
			n++;
		end
		repeat (2) @(posedge mclk_i);
		#1;
		// A bus that never enabled yields an unknown word, which every compare refuses
		w = (n < 10) ? data_o : 'x;
		repeat (hold) @(posedge mclk_i);
		#1;
		w_late = data_o;
		@(posedge mclk_i);
		pins_o.read_strobe_n <= 1'b1;
		pins_o.chip_select_n <= 1'b1;
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic read(input logic [2:0] mode, input logic bm, output logic [WORD_W-1:0] w);
		logic [WORD_W-1:0] late;
		read_hold(mode, bm, 0, w, late);
	endtask
endmodule

`default_nettype wire

// ### test/result_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Bench
// ==================================================
module result_readout_tb_top
	import readout_pkg::*;
;
	localparam int HC = 1;

	logic        mclk;
	logic        rst;
	host_pins_t  pins;
	logic [2:0]  trig_n;
	logic [15:0] data;
	logic        oe;
	logic        busy_n;
	logic [1:0]  pair;
	logic [2:0]  hold;
	logic [11:0] first;
	logic [11:0] second;
	logic [15:0] w;
	logic [15:0] w2;
	int          fail_count;
	int          check_count;

	// Core results carry the pair number in their low bits
	assign first = {4'ha, 6'h00, pair};
	assign second = {4'h5, 6'h00, pair};

	result_readout #(.HALF_CYCLES(HC)) result_readout_i (
		.mclk_i(mclk), .reset_i(rst), .read_strobe_n_i(pins.read_strobe_n),
		.chip_select_n_i(pins.chip_select_n), .byte_mode_i(pins.byte_mode),
		.mode_select_i(pins.mode_select), .data_o(data), .data_oe_o(oe),
		.sample_trigger_n_i(trig_n), .core_first_i(first), .core_second_i(second),
		.core_pair_o(pair), .busy_n_o(busy_n), .hold_o(hold));
	readout_host_model readout_host_model_i (
		.mclk_i(mclk), .data_o(data), .data_oe_o(oe), .pins_o(pins));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	function automatic logic [15:0] exp_word(input logic [2:0] ch);
		return {1'b1, ch, ch[0] ? 4'h5 : 4'ha, 6'h00, ch[2:1]};
	endfunction

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic pulse(input logic [2:0] mask);
		@(posedge mclk);
		trig_n <= ~mask;
		repeat (3) @(posedge mclk);
		trig_n <= 3'h7;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!(hold === 3'h0 && busy_n === 1'b1) && n < 600);
		if (n >= 600) begin
			fail_count++;
			$display("unexpected at %0t: converter never went idle", $time);
		end
		repeat (4) @(posedge mclk);
	endtask

	task automatic read_empty;
		readout_host_model_i.read(3'h7, 1'b0, w);
		check_word({w[15], 15'h0}, 16'h0);
	endtask

	task automatic fifo_expect(input int n, input logic [2:0] seq [6]);
		for (int i = 0; i < n; i++) begin
			readout_host_model_i.read(3'h7, 1'b0, w);
			check_word(w, exp_word(seq[i]));
		end
		read_empty();
	endtask

	task automatic conv_order;
		read_empty();
		pulse(3'b010);
		repeat (4) @(posedge mclk);
		pulse(3'b101);
		wait_idle();
		fifo_expect(6, '{3'h2, 3'h3, 3'h0, 3'h1, 3'h4, 3'h5});
	endtask

	task automatic direct_all;
		for (int ch = 0; ch < 6; ch++) begin
			readout_host_model_i.read(3'(ch), 1'b0, w);
			check_word(w, exp_word(3'(ch)));
		end
	endtask

	task automatic cycle_all;
		for (int i = 0; i < 7; i++) begin
			readout_host_model_i.read(3'h6, 1'b0, w);
			check_word(w, exp_word(3'(i % 6)));
		end
	endtask

	task automatic byte_read;
		logic [15:0] e;
		// Channel 1 comes from the cycle pointer, left at 1 by cycle_all
		for (int ch = 1; ch < 4; ch++) begin
			e = exp_word(3'(ch));
			readout_host_model_i.read((ch == 1) ? 3'h6 : 3'(ch), 1'b1, w);
			readout_host_model_i.read((ch == 1) ? 3'h6 : 3'(ch), 1'b1, w2);
			check_word(w, {8'h00, e[7:0]});
			check_word(w2, {8'h00, e[15:8]});
		end
		readout_host_model_i.read(3'h6, 1'b0, w);
		check_word(w, exp_word(3'h2));
	endtask

	task automatic armed_ignore;
		read_empty();
		pulse(3'b010);
		repeat (6) @(posedge mclk);
		pulse(3'b010);
		wait_idle();
		fifo_expect(2, '{3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0});
	endtask

	task automatic fifo_three;
		read_empty();
		repeat (3) begin
			pulse(3'b001);
			wait_idle();
		end
		fifo_expect(6, '{3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1});
	endtask

	task automatic reset_mid;
		pulse(3'b100);
		repeat (10) @(posedge mclk);
		rst <= 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (60) @(posedge mclk);
		readout_host_model_i.read(3'h0, 1'b0, w);
		check_word(w, 16'h0);
		readout_host_model_i.read(3'h4, 1'b0, w);
		check_word(w, 16'h0);
	endtask

	// Pair A latches while a long read of its cleared register is under way
	task automatic hold_off;
		pulse(3'b001);
		readout_host_model_i.read_hold(3'h0, 1'b0, 40, w, w2);
		check_word(w, 16'h0);
		check_word(w2, 16'h0);
		readout_host_model_i.read(3'h0, 1'b0, w);
		check_word(w, exp_word(3'h0));
	endtask

	initial begin
		rst = 1'b1;
		trig_n = 3'h7;
		fail_count = 0;
		check_count = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		conv_order();
		direct_all();
		cycle_all();
		byte_read();
		armed_ignore();
		fifo_three();
		reset_mid();
		hold_off();
		final_report();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		final_report();
	end
endmodule

`default_nettype wire
